// ==== rtl/hssq_pkg.sv ====
package hssq_pkg;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int unsigned CLK_FREQ_HZ = 25000000;
	// Hold period in milliseconds; plain default.
	localparam int unsigned HOLD_MS = 100;
	localparam int unsigned HOLD_CYCLES = CLK_FREQ_HZ / 1000 * HOLD_MS;
	localparam int unsigned SYNC_STAGES = 2;

	// ---------------------------------------------------------------
	// Supply select encodings
	// ---------------------------------------------------------------
	localparam logic [1:0] SEL_HIGH_ONLY = 2'h0;
	localparam logic [1:0] SEL_LOW_ONLY = 2'h1;
	localparam logic [1:0] SEL_BOTH = 2'h2;

	// Raw asynchronous inputs gathered into one word for synchronising.
	typedef struct packed {
		logic seat_detect_a_n;
		logic seat_detect_b_n;
		logic [1:0] supply_select;
		logic bus_high_ok;
		logic bus_low_ok;
		logic card_high_ok;
		logic card_low_ok;
		logic host_power_permit;
		logic host_reset_in_n;
	} hssq_in_t;

	localparam int unsigned IN_W = $bits(hssq_in_t);

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_SEATED = 3'h1,
		ST_RAMP = 3'h2,
		ST_HOLD = 3'h3,
		ST_READY = 3'h4
	} hssq_state_t;

endpackage

// ==== rtl/hssq_sync.sv ====
`timescale 1ns/10ps
module hssq_sync
	import hssq_pkg::*;
#(
	parameter int unsigned WIDTH = 1
) (
	input wire logic mclk_i, // Design clock.
	input wire logic rst_n_i, // Asynchronous reset, active low.
	input wire logic [WIDTH-1:0] d_i, // Asynchronous inputs.
	input wire logic [WIDTH-1:0] rst_val_i, // Safe idle level, taken after release.
	output logic [WIDTH-1:0] q_o // Synchronised inputs.
);

	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] stage;
	logic [1:0] fill;

	if (WIDTH < 1) begin : g_width_check
		$error("hssq_sync: WIDTH must be at least 1");
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta <= '0;
			stage <= '0;
			fill <= 2'h0;
		end else begin
			meta <= d_i;
			stage <= meta;
			fill <= {fill[0], 1'b1};
		end
	end

	// Until both stages hold sampled data the idle level stands in, so no false event follows.
	assign q_o = fill[1] ? stage : rst_val_i;

endmodule

// ==== rtl/hssq_top.sv ====
`timescale 1ns/10ps
module hssq_top
	import hssq_pkg::*;
#(
	parameter int unsigned HOLD_COUNT = HOLD_CYCLES
) (
	input wire logic mclk_i, // Design clock, 25 MHz.
	input wire logic rst_n_i, // Pre-charge power-on reset, active low.
	input wire logic seat_detect_a_n_i, // Seat switch A, low when seated.
	input wire logic seat_detect_b_n_i, // Seat switch B, low when seated.
	input wire logic [1:0] supply_select_i, // Which bus supplies to watch.
	input wire logic bus_high_ok_i, // 5 V bus at or above trip.
	input wire logic bus_low_ok_i, // 3.3 V bus at or above trip.
	input wire logic card_high_ok_i, // Card 5 V at or above trip.
	input wire logic card_low_ok_i, // Card 3.3 V at or above trip.
	input wire logic host_power_permit_i, // Host power permit, low inhibits.
	input wire logic host_reset_in_n_i, // Host reset, active low.
	output logic gate_out_low_rail_o, // 3.3 V gate on.
	output logic gate_out_high_rail_o, // 5 V gate on.
	output logic high_side_driver_en_n_o, // Driver enable, active low.
	output logic card_supply_ok_o, // Card supplies valid.
	output logic signals_ready_n_o, // Card ready, active low.
	output logic card_reset_n_o, // Card reset, active low.
	output logic card_reset_o // Card reset, active high.
);

	localparam int unsigned CW = $clog2(HOLD_COUNT + 1);

	// The counter width follows the period, so any positive count fits.
	if (HOLD_COUNT < 1) begin : g_hold_check
		$error("hssq_top: HOLD_COUNT must be at least 1");
	end

	// ---------------------------------------------------------------
	// Input synchronisation
	// ---------------------------------------------------------------
	hssq_in_t raw;
	hssq_in_t syn;
	hssq_in_t idle;

	assign raw = '{seat_detect_a_n_i, seat_detect_b_n_i, supply_select_i, bus_high_ok_i,
		bus_low_ok_i, card_high_ok_i, card_low_ok_i, host_power_permit_i, host_reset_in_n_i};
	// Idle levels stand in until the synchroniser has filled: unseated, resets held, no power.
	assign idle = '{
		seat_detect_a_n: 1'b1,
		seat_detect_b_n: 1'b1,
		supply_select: SEL_BOTH,
		bus_high_ok: 1'b0,
		bus_low_ok: 1'b0,
		card_high_ok: 1'b0,
		card_low_ok: 1'b0,
		host_power_permit: 1'b0,
		host_reset_in_n: 1'b0
	};

	hssq_sync #(
		.WIDTH(IN_W)
	) u_sync (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.d_i(raw),
		.rst_val_i(idle),
		.q_o(syn)
	);

	// ---------------------------------------------------------------
	// Decode
	// ---------------------------------------------------------------
	function automatic logic supplies_ok(input logic [1:0] sel, input logic hi, input logic lo);
		logic r;
		r = 1'b0;
		unique case (sel)
			SEL_HIGH_ONLY: r = hi;
			SEL_LOW_ONLY: r = lo;
			SEL_BOTH: r = hi & lo;
			default: r = hi & lo;
		endcase
		return r;
	endfunction

	// States in which the gates are on.
	function automatic logic is_powered(input hssq_state_t s);
		return (s == ST_RAMP) || (s == ST_HOLD) || (s == ST_READY);
	endfunction

	// ---------------------------------------------------------------
	// Sequencer conditions
	// ---------------------------------------------------------------

	hssq_state_t state;
	hssq_state_t next_state;
	logic [1:0] sel_held;
	logic [1:0] next_sel_held;
	logic [CW-1:0] hold_cnt;
	logic [CW-1:0] next_hold_cnt;

	wire seated = !syn.seat_detect_a_n && !syn.seat_detect_b_n;
	wire permit = syn.host_power_permit;
	wire host_rst = !syn.host_reset_in_n;
	wire bus_ok = supplies_ok(sel_held, syn.bus_high_ok, syn.bus_low_ok);
	wire card_ok = supplies_ok(sel_held, syn.card_high_ok, syn.card_low_ok);
	wire abort = !seated || !permit;
	// The hold ends one edge after the count has reached HOLD_COUNT.
	wire hold_done = (hold_cnt == CW'(HOLD_COUNT));
	wire powered = is_powered(state);

	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_sel_held = sel_held;
		next_hold_cnt = hold_cnt;
		unique case (state)
			ST_IDLE: begin
				if (seated) begin
					// The selection is taken once per seating; a change needs a reseat.
					next_sel_held = syn.supply_select;
					next_state = ST_SEATED;
				end
			end
			ST_SEATED: begin
				if (!seated) begin
					next_state = ST_IDLE;
				end else if (bus_ok && permit) begin
					next_state = ST_RAMP;
				end
			end
			ST_RAMP: begin
				// The timer stays clear until card supplies and host lines let it run.
				next_hold_cnt = '0;
				if (card_ok && !host_rst && permit) begin
					next_state = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (host_rst || !card_ok) begin
					next_hold_cnt = '0;
					next_state = ST_RAMP;
				end else if (hold_done) begin
					next_state = ST_READY;
				end else begin
					next_hold_cnt = hold_cnt + CW'(1);
				end
			end
			ST_READY: begin
				if (host_rst || !card_ok) begin
					next_hold_cnt = '0;
					next_state = ST_RAMP;
				end
			end
			default: next_state = ST_IDLE;
		endcase
		// Loss of seating, permit or a watched bus outranks every step above.
		if (powered && (abort || !bus_ok)) begin
			next_state = seated ? ST_SEATED : ST_IDLE;
			next_hold_cnt = '0;
		end
	end

	// ---------------------------------------------------------------
	// State register
	// ---------------------------------------------------------------

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= ST_IDLE;
			sel_held <= SEL_BOTH;
			hold_cnt <= '0;
		end else begin
			state <= next_state;
			sel_held <= next_sel_held;
			hold_cnt <= next_hold_cnt;
		end
	end

	// ---------------------------------------------------------------
	// Outputs, all registered
	// ---------------------------------------------------------------
	wire next_power = is_powered(next_state);
	wire next_ready = (next_state == ST_READY);
	// Both reset forms come from one decode so they can never disagree.
	wire next_reset = !next_ready;
	wire next_card_ok = next_power && card_ok;

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			gate_out_low_rail_o <= 1'b0;
			gate_out_high_rail_o <= 1'b0;
			high_side_driver_en_n_o <= 1'b1;
			card_supply_ok_o <= 1'b0;
			signals_ready_n_o <= 1'b1;
			card_reset_n_o <= 1'b0;
			card_reset_o <= 1'b1;
		end else begin
			gate_out_low_rail_o <= next_power;
			gate_out_high_rail_o <= next_power;
			high_side_driver_en_n_o <= !next_power;
			card_supply_ok_o <= next_card_ok;
			signals_ready_n_o <= !next_ready;
			card_reset_n_o <= !next_reset;
			card_reset_o <= next_reset;
		end
	end

endmodule

// ==== dv/hssq_far_end.sv ====
`timescale 1ns/10ps
module hssq_far_end (
	input wire logic mclk_i, // Clock.
	input wire logic gate_on_i, // Gates on.
	input wire logic card_reset_n_i, // Card reset.
	input wire logic [2:0] ramp_i, // Ramp cycles.
	output logic card_ok_o, // Card supplies good.
	output logic xcvr_en_n_o // Transceiver enable.
);
	logic [2:0] ramp;
	always @(posedge mclk_i) begin
		ramp <= gate_on_i ? ((ramp == ramp_i) ? ramp : ramp + 3'h1) : 3'h0;
	end
	assign card_ok_o = gate_on_i && (ramp == ramp_i);
	// The transceiver stays disabled while the card is held in reset.
	assign xcvr_en_n_o = !card_reset_n_i;
endmodule

// ==== dv/hssq_properties.sv ====
`timescale 1ns/10ps
module hssq_properties
	import hssq_pkg::*;
#(
	parameter int unsigned HOLD_COUNT = 8
) (
	input wire logic mclk_i, // Clock.
	input wire logic rst_n_i, // Reset.
	input wire logic seat_detect_a_n_i, // Seat A.
	input wire logic seat_detect_b_n_i, // Seat B.
	input wire logic bus_high_ok_i, // Bus 5 V.
	input wire logic bus_low_ok_i, // Bus 3.3 V.
	input wire logic host_power_permit_i, // Permit.
	input wire logic host_reset_in_n_i, // Host reset.
	input wire logic gate_out_low_rail_o, // Gate.
	input wire logic gate_out_high_rail_o, // Gate.
	input wire logic high_side_driver_en_n_o, // Driver.
	input wire logic card_supply_ok_o, // Card ok.
	input wire logic signals_ready_n_o, // Ready.
	input wire logic card_reset_n_o, // Reset.
	input wire logic card_reset_o // Reset.
);
	// ---------------------------------------------
	// Counts edges spent holding with supplies good.
	// ---------------------------------------------
	logic [31:0] held;
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			held <= '0;
		end else begin
			held <= (card_supply_ok_o && card_reset_o) ? held + 32'h1 : '0;
		end
	end
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	a_reset_pair: assert property (card_reset_n_o != card_reset_o)
		else $error("reset pair");
	a_gates_agree: assert property (gate_out_high_rail_o == gate_out_low_rail_o &&
		gate_out_high_rail_o != high_side_driver_en_n_o) else $error("gates");
	a_power_cause: assert property ($rose(gate_out_high_rail_o) |->
		$past(host_power_permit_i, 3) && !$past(seat_detect_a_n_i, 3) &&
		!$past(seat_detect_b_n_i, 3)) else $error("power on");
	a_open_drop: assert property ($past(gate_out_high_rail_o) &&
		($past(seat_detect_b_n_i, 3) || !$past(host_power_permit_i, 3)) |->
		!gate_out_high_rail_o && card_reset_o) else $error("drop");
	a_bus_drop: assert property ($past(gate_out_high_rail_o) &&
		!$past(bus_high_ok_i, 3) && !$past(bus_low_ok_i, 3) |-> !gate_out_high_rail_o)
		else $error("bus drop");
	a_host_reset: assert property (!$past(host_reset_in_n_i, 3) |-> card_reset_o)
		else $error("host reset");
	a_hold_len: assert property ($fell(card_reset_o) |-> held >= HOLD_COUNT)
		else $error("hold");
	a_ready_state: assert property (signals_ready_n_o == card_reset_o &&
		(signals_ready_n_o || card_supply_ok_o)) else $error("ready");
	a_card_ok_gate: assert property (card_supply_ok_o |-> gate_out_high_rail_o)
		else $error("card ok without power");
	cover property ($fell(signals_ready_n_o));
	cover property ($fell(gate_out_high_rail_o));
	cover property ($rose(card_reset_o) && gate_out_high_rail_o);
endmodule
bind hssq_top hssq_properties #(.HOLD_COUNT(HOLD_COUNT)) i_hssq_properties (.*);

// ==== dv/test_hot_swap_power_sequencer.sv ====
`timescale 1ns/10ps
module test_hot_swap_power_sequencer
	import hssq_pkg::*;
;
	localparam int HOLD = 8;
	logic mclk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic sa = 1'b1, sb = 1'b1, bh = 1'b0, bl = 1'b0, perm = 1'b0, hrst_n = 1'b0;
	logic [1:0] sel = 2'h0;
	logic [2:0] ramp = 3'h0;
	logic [31:0] rnd = 32'hC68FD6AE;
	logic cok;
	wire [6:0] outs;
	int n_fail = 0, checks = 0;
	always #20 mclk_i = ~mclk_i;
	hssq_top #(.HOLD_COUNT(HOLD)) i_hssq_top (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
		.seat_detect_a_n_i(sa), .seat_detect_b_n_i(sb), .supply_select_i(sel),
		.bus_high_ok_i(bh), .bus_low_ok_i(bl), .card_high_ok_i(cok), .card_low_ok_i(cok),
		.host_power_permit_i(perm), .host_reset_in_n_i(hrst_n),
		.gate_out_high_rail_o(outs[6]), .gate_out_low_rail_o(outs[5]),
		.high_side_driver_en_n_o(outs[4]), .card_supply_ok_o(outs[3]),
		.signals_ready_n_o(outs[2]), .card_reset_n_o(outs[1]), .card_reset_o(outs[0]));
	hssq_far_end i_hssq_far_end (.mclk_i(mclk_i), .gate_on_i(outs[6]),
		.card_reset_n_i(outs[1]), .ramp_i(ramp), .card_ok_o(cok), .xcvr_en_n_o());
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Bus pair {high, low} that fails the latched selection.
	function automatic logic [1:0] bad_bus(input logic [1:0] m, input logic r);
		return (m == SEL_HIGH_ONLY) ? 2'h1 : (m == SEL_LOW_ONLY) ? 2'h2 : {r, !r};
	endfunction
	task automatic step(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask
	task automatic end_sim();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [6:0] got, input logic [6:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %0t outputs %h not %h", $time, got, exp);
		end
	endtask
	task automatic chk_n(input int got, input int exp);
		checks++;
		if (got != exp) begin
			n_fail++;
			$display("MISMATCH %0t cycles %0d not %0d", $time, got, exp);
		end
	endtask
	task automatic wait_for(input logic [6:0] exp, output int n);
		n = 0;
		while (outs !== exp && n < 200) begin
			step(1);
			n++;
		end
		chk(outs, exp);
		if (outs !== exp) begin
			end_sim();
		end
	endtask
	initial begin
		int n;
		step(12);
		rst_n_i = 1'b1;
		step(1);
		chk(outs, 7'h15);
		hrst_n = 1'b1;
		for (int k = 0; k < 4; k++) begin
			rnd = lfsr(rnd);
			ramp = rnd[2:0];
			sel = 2'(k);
			{bh, bl} = 2'h3;
			step(4);
			sa = 1'b0;
			sb = 1'b0;
			step(4);
			sel = rnd[4:3];
			step(10);
			chk(outs, 7'h15);
			{bh, bl} = bad_bus(2'(k), rnd[5]);
			perm = 1'b1;
			step(10);
			chk(outs, 7'h15);
			{bh, bl} = 2'h3;
			wait_for(7'h65, n);
			wait_for(7'h6D, n);
			wait_for(7'h6A, n);
			chk_n(n, HOLD + 1);
			hrst_n = 1'b0;
			step(3);
			chk(outs & 7'h77, 7'h65);
			step(2 * HOLD);
			chk(outs & 7'h77, 7'h65);
			hrst_n = 1'b1;
			wait_for(7'h6A, n);
			chk_n(n, HOLD + 4);
			case (k)
				0: sa = 1'b1;
				1: sb = 1'b1;
				2: perm = 1'b0;
				default: {bh, bl} = 2'h0;
			endcase
			step(3);
			chk(outs, 7'h15);
			sa = 1'b1;
			sb = 1'b1;
			perm = 1'b0;
		end
		end_sim();
	end
endmodule
